// ---- src/adccc_consts.svh ----
// Purpose: constants of the converter control block
// Assumes: register indices map to byte addresses as index times four
// Notes:   one aligned 32-bit word per register, byte data in bits 7:0
`ifndef ADCCC_CONSTS_SVH
`define ADCCC_CONSTS_SVH

// ==========================================================
// register indices
`define ADCCC_IDX_RESULT_HI   10'h050
`define ADCCC_IDX_RESULT_LO   10'h051
`define ADCCC_IDX_CONFIG      10'h052
`define ADCCC_IDX_IRQ_STATUS  10'h054
`define ADCCC_IDX_IRQ_MASK    10'h055

// ==========================================================
// configuration register fields
`define ADCCC_CFG_REF_BIT     7
`define ADCCC_CFG_JUST_HI     6
`define ADCCC_CFG_JUST_LO     5
`define ADCCC_CFG_GO_BIT      3
`define ADCCC_CFG_CHAN_HI     2
`define ADCCC_CFG_CHAN_LO     0
`define ADCCC_CFG_WRITE_MASK  8'hE7
`define ADCCC_CFG_RESET       8'h00

// ==========================================================
// interrupt bits and result shape
`define ADCCC_IRQ_DONE_BIT    0
`define ADCCC_IRQ_RESET       8'h00
`define ADCCC_RESULT_RESET    8'h00
`define ADCCC_RESULT_W        10
`define ADCCC_PAD_W           6

`endif

// ---- src/adccc_justify.sv ----
// Purpose: arrange a raw conversion value into a 16-bit result word
// Assumes: raw value is unsigned, width ADCCC_RESULT_W
// Notes:   purely combinational; the caller registers the output
`timescale 1ns/10ps
`include "adccc_consts.svh"

module adccc_justify (
  input  wire adccc_pkg::adccc_just_t   mode,
  input  wire logic [`ADCCC_RESULT_W-1:0] raw,
  output logic      [15:0]              word
);

  // ==========================================================
  // formatting
  always_comb begin
    unique case (mode)
      adccc_pkg::ADCCC_JUST_SIGNED: begin
        word = {{`ADCCC_PAD_W{~raw[`ADCCC_RESULT_W-1]}}, ~raw[`ADCCC_RESULT_W-1], raw[`ADCCC_RESULT_W-2:0]};
      end
      adccc_pkg::ADCCC_JUST_LEFT: begin
        word = {raw, {`ADCCC_PAD_W{1'b0}}};
      end
      // reserved code falls back to right aligned
      default: begin
        word = {{`ADCCC_PAD_W{1'b0}}, raw};
      end
    endcase
  end

endmodule

// ---- src/adccc_pkg.sv ----
// Purpose: shared types of the converter control block
// Assumes: constants live in adccc_consts.svh
// Notes:   no imports; users write adccc_pkg::name
package adccc_pkg;

  // ==========================================================
  // result justification codes
  typedef enum logic [1:0] {
    ADCCC_JUST_RIGHT    = 2'b00,
    ADCCC_JUST_SIGNED   = 2'b01,
    ADCCC_JUST_LEFT     = 2'b10,
    ADCCC_JUST_RESERVED = 2'b11
  } adccc_just_t;

  // ==========================================================
  // conversion sequencer states
  typedef enum logic {
    ADCCC_IDLE = 1'b0,
    ADCCC_BUSY = 1'b1
  } adccc_state_t;

endpackage

// ---- src/adccc_top.sv ----
// Purpose: converter control with AHB-Lite register slave
// Assumes: converter core runs on ref_clk and pulses conv_done once
// Notes:   zero wait state slave, always OKAY
//
// Behaviour
// - config bit 7 picks analog supply (0) or external reference pin (1).
// - justify field: 00 right, 01 signed, 10 left, 11 reserved.
// - writing 1 to start/done bit launches conversion on selected channel.
// - start/done bit reads 1 while a conversion runs.
// - start/done bit reads 0 once the last conversion finished.
// - channel field bits 2:0 route pin 0 to 7 to converter.
// - result readable as high byte and low byte registers.
`timescale 1ns/10ps
`include "adccc_consts.svh"

module adccc_top (
  input  wire  logic                      ref_clk,
  input  wire  logic                      resetn,
  input  wire  logic                      hsel,
  input  wire  logic [31:0]               haddr,
  input  wire  logic [1:0]                htrans,
  input  wire  logic                      hwrite,
  input  wire  logic [2:0]                hsize,
  input  wire  logic [31:0]               hwdata,
  input  wire  logic                      hready,
  output logic       [31:0]               hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  output logic                            irq,
  output logic                            conv_start,
  output logic       [2:0]                conv_channel,
  output logic                            conv_ref_external,
  output logic       [7:0]                pin_select,
  input  wire  logic                      conv_done,
  input  wire  logic [`ADCCC_RESULT_W-1:0] conv_result
);

  // ==========================================================
  // declarations
  logic                      dp_write_r;
  logic [9:0]                dp_index_r;
  logic [7:0]                cfg_r;
  logic [7:0]                result_hi_r;
  logic [7:0]                result_lo_r;
  logic [7:0]                irq_status_r;
  logic [7:0]                irq_mask_r;
  logic                      conv_start_r;
  adccc_pkg::adccc_state_t   state_r;
  logic                      addr_phase;
  logic                      wr_cfg;
  logic                      wr_status;
  logic                      wr_mask;
  logic                      start_req;
  logic                      finish;
  logic [15:0]               formatted;
  logic [7:0]                rd_byte;
  logic [7:0]                cfg_nxt;
  logic                      busy_nxt;
  logic [7:0]                result_hi_nxt;
  logic [7:0]                result_lo_nxt;
  logic [7:0]                irq_status_nxt;
  logic [7:0]                irq_mask_nxt;

  // word index of a byte address; unaligned or high bits miss every register
  function automatic logic [9:0] word_index(input logic [31:0] addr);
    if (addr[1:0] != 2'b00 || addr[31:12] != 20'h00000) begin
      word_index = 10'h3FF;
    end else begin
      word_index = addr[11:2];
    end
  endfunction

  // ==========================================================
  // bus slave
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign addr_phase = hsel && hready && htrans[1];

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dp_write_r <= 1'b0;
      dp_index_r <= 10'h000;
    end else begin
      dp_write_r <= addr_phase && hwrite;
      dp_index_r <= addr_phase ? word_index(haddr) : 10'h000;
    end
  end

  assign wr_cfg    = dp_write_r && (dp_index_r == `ADCCC_IDX_CONFIG);
  assign wr_status = dp_write_r && (dp_index_r == `ADCCC_IDX_IRQ_STATUS);
  assign wr_mask   = dp_write_r && (dp_index_r == `ADCCC_IDX_IRQ_MASK);

  // next values: a read addressed in the data phase of a write must see that write,
  // otherwise software polling go right after a start would read a false done
  assign cfg_nxt        = wr_cfg ? (hwdata[7:0] & `ADCCC_CFG_WRITE_MASK) : cfg_r;
  // busy from the edge that launches the conversion
  assign busy_nxt       = (state_r == adccc_pkg::ADCCC_BUSY) ? !conv_done : start_req;
  assign result_hi_nxt  = finish ? formatted[15:8] : result_hi_r;
  assign result_lo_nxt  = finish ? formatted[7:0] : result_lo_r;
  assign irq_status_nxt = (irq_status_r & ~(wr_status ? hwdata[7:0] : 8'h00) & 8'h01) | {7'h00, finish};
  assign irq_mask_nxt   = wr_mask ? (hwdata[7:0] & 8'h01) : irq_mask_r;

  // read value picked in the address phase, held in a flop for the data phase
  always_comb begin
    unique case (word_index(haddr))
      `ADCCC_IDX_RESULT_HI:  rd_byte = result_hi_nxt;
      `ADCCC_IDX_RESULT_LO:  rd_byte = result_lo_nxt;
      // go bit shows the running conversion
      `ADCCC_IDX_CONFIG:     rd_byte = {cfg_nxt[7:5], 1'b0, busy_nxt, cfg_nxt[2:0]};
      `ADCCC_IDX_IRQ_STATUS: rd_byte = irq_status_nxt;
      `ADCCC_IDX_IRQ_MASK:   rd_byte = irq_mask_nxt;
      default:               rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= {24'h000000, rd_byte};
    end
  end

  // ==========================================================
  // configuration register
  // go bit and reserved bit are not stored; go reads back the sequencer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_r <= `ADCCC_CFG_RESET;
    end else if (wr_cfg) begin
      cfg_r <= hwdata[7:0] & `ADCCC_CFG_WRITE_MASK;
    end
  end

  assign conv_ref_external = cfg_r[`ADCCC_CFG_REF_BIT];
  assign conv_channel      = cfg_r[`ADCCC_CFG_CHAN_HI:`ADCCC_CFG_CHAN_LO];
  assign pin_select        = 8'h01 << conv_channel;

  // ==========================================================
  // conversion sequencer
  // a start while busy is ignored: the running conversion is not restarted
  assign start_req = wr_cfg && hwdata[`ADCCC_CFG_GO_BIT];
  assign finish    = (state_r == adccc_pkg::ADCCC_BUSY) && conv_done;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= adccc_pkg::ADCCC_IDLE;
    end else begin
      unique case (state_r)
        adccc_pkg::ADCCC_IDLE: begin
          if (start_req) begin
            state_r <= adccc_pkg::ADCCC_BUSY;
          end
        end
        adccc_pkg::ADCCC_BUSY: begin
          if (conv_done) begin
            state_r <= adccc_pkg::ADCCC_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      conv_start_r <= 1'b0;
    end else begin
      conv_start_r <= start_req && (state_r == adccc_pkg::ADCCC_IDLE);
    end
  end

  assign conv_start = conv_start_r;

  // ==========================================================
  // result registers
  adccc_justify u_justify (
    .mode (adccc_pkg::adccc_just_t'(cfg_r[`ADCCC_CFG_JUST_HI:`ADCCC_CFG_JUST_LO])),
    .raw  (conv_result),
    .word (formatted)
  );

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      result_hi_r <= `ADCCC_RESULT_RESET;
      result_lo_r <= `ADCCC_RESULT_RESET;
    end else if (finish) begin
      result_hi_r <= formatted[15:8];
      result_lo_r <= formatted[7:0];
    end
  end

  // ==========================================================
  // interrupts
  // set beats a simultaneous write-one clear so no completion is lost
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_status_r <= `ADCCC_IRQ_RESET;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_mask_r <= `ADCCC_IRQ_RESET;
    end else if (wr_mask) begin
      irq_mask_r <= hwdata[7:0] & 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_r & irq_mask_r);
    end
  end

endmodule

// ---- tb/adc_config_control_tb.sv ----
// Purpose: register level tests of converter control
// Assumes: slave answers with zero waits
// Notes:   one bus task serves reads and writes
`timescale 1ns/10ps
`include "adccc_consts.svh"
module adc_config_control_tb;
  localparam logic [9:0] i_hi = `ADCCC_IDX_RESULT_HI;
  localparam logic [9:0] i_lo = `ADCCC_IDX_RESULT_LO;
  localparam logic [9:0] i_cfg = `ADCCC_IDX_CONFIG;
  localparam logic [9:0] i_st = `ADCCC_IDX_IRQ_STATUS;
  localparam logic [9:0] i_mk = `ADCCC_IDX_IRQ_MASK;
  logic        ref_clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic        hready, hresp, irq, start, ref_ext, done;
  logic [2:0]  chan;
  logic [7:0]  pins, lat = 8'h01;
  logic [9:0]  res, val = 10'h000;
  int          mismatches = 0, cmp_count = 0;
  always #2.5 ref_clk = ~ref_clk;
  adccc_top dut_u (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .irq(irq), .conv_start(start), .conv_channel(chan), .conv_ref_external(ref_ext),
    .pin_select(pins), .conv_done(done), .conv_result(res));
  adccc_core_model core_u (.ref_clk(ref_clk), .conv_start(start), .lat(lat), .val(val),
    .conv_done(done), .conv_result(res));
  // ==========================================
  // bus, compare and closing tasks
  task automatic bus(input logic [9:0] idx, input logic wr, input logic [7:0] d, output logic [31:0] q);
    haddr <= {20'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge ref_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    give_verdict();
  end
  // ==========================================
  // tests
  initial begin
    logic [31:0] q;
    logic [9:0]  r;
    logic [15:0] ex;
    int          n;
    logic [9:0]  tab [6] = '{i_hi, i_lo, i_cfg, i_st, i_mk, 10'h3FF};
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    hsel <= 1'b1;
    @(posedge ref_clk);
    bus(i_hi, 1'b1, 8'hFF, q);
    foreach (tab[i]) begin
      bus(tab[i], 1'b0, 8'h00, q);
      chk("reset value", q, 32'h0);
    end
    $display("reset test done");
    for (int c = 0; c < 8; c++) begin
      bus(i_cfg, 1'b1, {c[0], 4'h0, c[2:0]}, q);
      bus(i_cfg, 1'b0, 8'h00, q);
      chk("config", q, {c[0], 4'h0, c[2:0]});
      chk("pins", pins, 8'h01 << c);
      chk("channel", chan, c[2:0]);
      chk("reference", ref_ext, c[0]);
    end
    $display("channel test done");
    for (int j = 0; j < 4; j++) begin
      r = {j[1:0], 8'hA5};
      val <= r;
      lat <= 8'(12 + 9 * j);
      bus(i_mk, 1'b1, {7'h0, j[0]}, q);
      bus(i_cfg, 1'b1, {1'b0, j[1:0], 5'h0A}, q);
      bus(i_cfg, 1'b1, {1'b0, j[1:0], 5'h0A}, q);
      bus(i_cfg, 1'b0, 8'h00, q);
      chk("busy", q[3], 1'b1);
      n = 0;
      do begin
        bus(i_cfg, 1'b0, 8'h00, q);
        n++;
      end while (q[3] !== 1'b0 && n < 50);
      chk("done", q, {1'b0, j[1:0], 5'h02});
      ex = (j == 1) ? {{6{~r[9]}}, ~r[9], r[8:0]} : (j == 2) ? {r, 6'h00} : {6'h00, r};
      bus(i_hi, 1'b0, 8'h00, q);
      chk("high byte", q, ex[15:8]);
      bus(i_lo, 1'b0, 8'h00, q);
      chk("low byte", q, ex[7:0]);
      chk("irq", irq, j[0]);
      bus(i_st, 1'b0, 8'h00, q);
      chk("status", q, 32'h1);
      bus(i_st, 1'b1, 8'h01, q);
      bus(i_st, 1'b0, 8'h00, q);
      chk("status clear", q, 32'h0);
      @(posedge ref_clk);
      chk("irq clear", irq, 1'b0);
    end
    $display("conversion test done");
    give_verdict();
  end
endmodule

// ---- tb/adccc_checker.sv ----
// Purpose: port checks of the converter control block
// Assumes: zero wait state register slave, one clock domain
// Notes:   sees the top ports only; bound below
`timescale 1ns/10ps
`include "adccc_consts.svh"
module adccc_checker (
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        irq,
  input wire logic        conv_start,
  input wire logic [2:0]  conv_channel,
  input wire logic        conv_ref_external,
  input wire logic [7:0]  pin_select,
  input wire logic        conv_done
);
  // ==========================================
  // helpers: config write phase and busy copy
  logic aw_cfg_r;
  logic busy_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) aw_cfg_r <= 1'b0;
    else aw_cfg_r <= hsel & hready & htrans[1] & hwrite & (haddr == {20'h0, `ADCCC_IDX_CONFIG, 2'b00});
  end
  // busy copy lags one edge, start never meets done
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) busy_r <= 1'b0;
    else if (conv_start) busy_r <= 1'b1;
    else if (conv_done) busy_r <= 1'b0;
  end
  // ==========================================
  // assertions
  a_pin_onehot: assert property ($onehot(pin_select) && pin_select[conv_channel])
    else $error("pin select is not the decoded channel");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse longer than one cycle");
  a_start_idle: assert property (conv_start |-> !busy_r)
    else $error("start issued while converting");
  a_start_cause: assert property (conv_start |-> $past(aw_cfg_r) && $past(hwdata[3]))
    else $error("start without a config write of go");
  a_chan_cause: assert property ($changed(conv_channel) |-> $past(aw_cfg_r))
    else $error("channel moved without config write");
  a_ref_cause: assert property ($changed(conv_ref_external) |-> $past(aw_cfg_r))
    else $error("reference moved without config write");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave stalled or errored");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data above byte not zero");
  c_start: cover property (conv_start);
  c_done: cover property (busy_r && conv_done);
  c_irq: cover property ($rose(irq));
endmodule

bind adccc_top adccc_checker chk_u (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .conv_start(conv_start), .conv_channel(conv_channel),
  .conv_ref_external(conv_ref_external), .pin_select(pin_select), .conv_done(conv_done));

// ---- tb/adccc_core_model.sv ----
// Purpose: converter core stand-in
// Assumes: start pulse is one cycle on ref_clk
// Notes:   latency and value set by the bench
`timescale 1ns/10ps
module adccc_core_model (
  input  wire logic       ref_clk,
  input  wire logic       conv_start,
  input  wire logic [7:0] lat,
  input  wire logic [9:0] val,
  output logic            conv_done,
  output logic      [9:0] conv_result
);
  // ==========================================
  // countdown, result only valid with done
  int cnt = 0;
  initial begin
    conv_done = 1'b0;
    conv_result = 10'h000;
  end
  always @(posedge ref_clk) begin
    conv_done <= 1'b0;
    conv_result <= ~conv_result;
    if (conv_start) cnt <= lat;
    else if (cnt == 1) begin
      conv_done <= 1'b1;
      conv_result <= val;
      cnt <= 0;
    end
    else if (cnt > 1) cnt <= cnt - 1;
  end
endmodule
